// file: rtl/sarrd_pkg.sv
/*
 * Shared constants of the serial converter readout: word layout,
 * link pulse counts and timing figures for both ends.
 * Assumes a 40 MHz system clock on both ends.
 */
package sarrd_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_W   = 16;
  localparam int unsigned SIGN_BIT   = RESULT_W - 1;
  localparam int unsigned BITCNT_W   = 5;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h10;  // Bits in one result word

  // ----------------------------------------------------------------
  // Calibration request
  // ----------------------------------------------------------------
  localparam int unsigned CALCNT_W   = 11;
  localparam logic [CALCNT_W-1:0] CAL_PULSES = 11'h400;  // 1024 pulses

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_MHZ     = 40;
  localparam int unsigned CONV_TIME_NS = 700;  // Conversion time, plain default
  localparam int unsigned CAL_TIME_MS  = 500;  // Calibration time
  localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned CAL_CYCLES   = CAL_TIME_MS * MCLK_MHZ * 1000;
  localparam int unsigned TMR_W        = 25;
  localparam logic [TMR_W-1:0] SCLK_HALF  = 25'h0000004;  // Host clock half period
  localparam logic [TMR_W-1:0] CONV_WAIT  = TMR_W'(CONV_CYCLES + 8);  // Host margin
  localparam logic [TMR_W-1:0] CAL_GUARD  = 25'h0000010;  // Host wait before polling

endpackage : sarrd_pkg

// file: rtl/sarrd_if.sv
/*
 * Four-wire link between converter and host controller.
 * Assumes a pull-up on the serial data line; the bench may replace it.
 */
`timescale 1ns/1ps
interface sarrd_if;

  // Link wires
  logic conversion_start_select;
  logic sclk;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;

  // Resolved data line, pulled high when released
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev  (input conversion_start_select, sclk, sdi, output sdo_o, sdo_oe);
  modport host (output conversion_start_select, sclk, sdi, input sdo);

endinterface : sarrd_if

// file: rtl/sarrd_device.sv
/*
 * Converter end: conversion timing, calibration and serial result shift.
 * Assumes sample_i holds the converted code as a two's complement word
 * and the link clock only runs while the host frames a transfer.
 */
`timescale 1ns/1ps

// Functional notes
// - Host drops MSB in unipolar single-ended use
// - Rising select edge starts a conversion
// - Conversion completes regardless of select level
// - Select line doubles as active-low chip select
// - Select low after conversion presents result
// - MSB first, shifted on serial clock fall
// - Host samples data on serial clock fall
// - Release data after last bit or select high
// - Host holds serial input high
// - 1024 clocks in standby request calibration
// - Drive data low while calibrating
// - Calibration lasts about 500 ms
// - Host watches pulled-up data for completion
// - Differential result in two's complement
module sarrd_device
  import sarrd_pkg::*;
#(
  parameter int unsigned CAL_LEN = CAL_CYCLES
) (
  // System clock and reset
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  // User side
  input  wire logic [RESULT_W-1:0] sample_i,
  output logic                     conv_busy_o,
  output logic                     cal_busy_o,
  // Link
  sarrd_if.dev                     link
);

  typedef enum logic [1:0] {SD_ACQ, SD_CONV, SD_DONE, SD_CAL} sarrd_dstate_e;

  sarrd_dstate_e       state_q;
  logic [TMR_W-1:0]    tmr_q;
  logic [RESULT_W-1:0] result_q;
  logic [2:0]          cs_sync_q;
  logic                cs_q;
  logic [2:0]          cal_sync_q;
  logic                cal_seen_q;
  logic                cs_rise;
  logic                cal_evt;
  logic [BITCNT_W-1:0] bit_cnt_q;
  logic [CALCNT_W-1:0] clk_cnt_q;
  logic                cal_tgl_q;
  logic                cs_n_raw;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------

  // Select high clears the bit and pulse counters without a clock edge
  assign cs_n_raw = link.conversion_start_select;

  // Result bit index, advanced on each falling serial clock edge until LAST_BIT
  always_ff @(negedge link.sclk or posedge cs_n_raw) begin
    if (cs_n_raw) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != LAST_BIT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Pulse count within one select-low frame, data bits included
  always_ff @(negedge link.sclk or posedge cs_n_raw) begin
    if (cs_n_raw) begin
      clk_cnt_q <= '0;
    end else if (clk_cnt_q != CAL_PULSES) begin
      clk_cnt_q <= clk_cnt_q + 11'h001;
    end
  end

  // Request toggle on the 1024th pulse
  always_ff @(negedge link.sclk or posedge srst_i) begin
    if (srst_i) begin
      cal_tgl_q <= 1'b0;
    end else if (!cs_n_raw && clk_cnt_q == CAL_PULSES - 11'h001) begin
      cal_tgl_q <= ~cal_tgl_q;
    end
  end

  // Data pin: low during calibration, result bit during readout
  always_comb begin
    link.sdo_o  = 1'b0;
    link.sdo_oe = 1'b0;
    if (state_q == SD_CAL) begin
      link.sdo_oe = 1'b1;
    end else if (state_q == SD_DONE && !cs_n_raw && bit_cnt_q != LAST_BIT) begin
      link.sdo_oe = 1'b1;
      link.sdo_o  = result_q[SIGN_BIT - 32'(bit_cnt_q)];
    end
  end

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------

  // Select pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cs_sync_q <= '0;
      cs_q      <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], link.conversion_start_select};
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_q <= cs_sync_q[2];
      end
    end
  end

  // Calibration toggle synchroniser
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cal_sync_q <= '0;
      cal_seen_q <= 1'b0;
    end else begin
      cal_sync_q <= {cal_sync_q[1:0], cal_tgl_q};
      if (cal_sync_q[1] == cal_sync_q[2]) begin
        cal_seen_q <= cal_sync_q[2];
      end
    end
  end

  assign cs_rise = (cs_sync_q[1] == cs_sync_q[2]) && cs_sync_q[2] && !cs_q;
  assign cal_evt = (cal_sync_q[1] == cal_sync_q[2]) && (cal_sync_q[2] != cal_seen_q);

  // Conversion and calibration sequencer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= SD_ACQ;
      tmr_q   <= '0;
    end else begin
      case (state_q)
        SD_ACQ, SD_DONE: begin
          if (cal_evt) begin
            state_q <= SD_CAL;
            tmr_q   <= '0;
          end else if (cs_rise) begin
            state_q <= SD_CONV;
            tmr_q   <= '0;
          end
        end
        SD_CONV: begin
          // Select level is not looked at here
          if (tmr_q == TMR_W'(CONV_CYCLES - 1)) begin
            state_q <= SD_DONE;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        SD_CAL: begin
          if (tmr_q == TMR_W'(CAL_LEN - 1)) begin
            state_q <= SD_ACQ;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        default: state_q <= SD_ACQ;
      endcase
    end
  end

  // Result capture at end of conversion, two's complement as supplied
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      result_q <= '0;
    end else if (state_q == SD_CONV && tmr_q == TMR_W'(CONV_CYCLES - 1)) begin
      result_q <= sample_i;
    end
  end

  // Status outputs
  assign conv_busy_o = (state_q == SD_CONV);
  assign cal_busy_o  = (state_q == SD_CAL);

endmodule : sarrd_device

// file: rtl/sarrd_host.sv
/*
 * Host end: two-entry result buffer and the link master that starts
 * conversions, reads results and requests calibration.
 * Assumes the link data line is pulled high when released.
 */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Two-entry buffer
// ------------------------------------------------------------------
module sarrd_fifo2
#(
  parameter int unsigned W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage and pointers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : sarrd_fifo2

// ------------------------------------------------------------------
// Link master
// ------------------------------------------------------------------
module sarrd_host
  import sarrd_pkg::*;
(
  // System clock and reset
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  // Requests
  input  wire logic                conv_req_i,
  input  wire logic                cal_req_i,
  input  wire logic                unipolar_i,
  output logic                     idle_o,
  output logic                     cal_busy_o,
  // Result stream
  output logic                     res_valid_o,
  input  wire logic                res_ready_i,
  output logic [RESULT_W-1:0]      res_data_o,
  // Link
  sarrd_if.host                    link
);

  typedef enum logic [2:0] {SH_IDLE, SH_CONV, SH_READ, SH_CAL, SH_CALWAIT} sarrd_hstate_e;

  sarrd_hstate_e       state_q;
  logic [TMR_W-1:0]    tmr_q;
  logic [CALCNT_W-1:0] edges_q;
  logic                sclk_q;
  logic                cs_q;
  logic [RESULT_W-1:0] shreg_q;
  logic [2:0]          sdo_sync_q;
  logic                sdo_q;
  logic                push;
  logic                buf_ready;
  logic                half_done;
  logic                fall;
  logic [CALCNT_W-1:0] edge_goal;
  logic [RESULT_W-1:0] word;

  // Link outputs
  assign link.conversion_start_select = cs_q;
  assign link.sclk                    = sclk_q;
  assign link.sdi                     = 1'b1;

  // Data pin synchroniser
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sdo_sync_q <= 3'h7;
      sdo_q      <= 1'b1;
    end else begin
      sdo_sync_q <= {sdo_sync_q[1:0], link.sdo};
      if (sdo_sync_q[1] == sdo_sync_q[2]) begin
        sdo_q <= sdo_sync_q[2];
      end
    end
  end

  assign half_done = (tmr_q == SCLK_HALF - 25'h0000001);
  assign fall      = half_done && sclk_q;
  assign edge_goal = (state_q == SH_READ) ? 11'(LAST_BIT) : CAL_PULSES;

  // Sequencer and serial clock divider
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= SH_IDLE;
      tmr_q   <= '0;
      edges_q <= '0;
      sclk_q  <= 1'b0;
      cs_q    <= 1'b0;
    end else begin
      case (state_q)
        SH_IDLE: begin
          tmr_q   <= '0;
          edges_q <= '0;
          if (cal_req_i) begin
            state_q <= SH_CAL;
          end else if (conv_req_i && buf_ready) begin
            cs_q    <= 1'b1;
            state_q <= SH_CONV;
          end
        end
        SH_CONV: begin
          if (tmr_q == CONV_WAIT) begin
            cs_q    <= 1'b0;
            tmr_q   <= '0;
            state_q <= SH_READ;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        SH_READ, SH_CAL: begin
          if (edges_q == edge_goal && !sclk_q) begin
            tmr_q   <= '0;
            state_q <= (state_q == SH_READ) ? SH_IDLE : SH_CALWAIT;
          end else if (half_done) begin
            tmr_q  <= '0;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              edges_q <= edges_q + 11'h001;
            end
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        SH_CALWAIT: begin
          if (tmr_q != CAL_GUARD) begin
            tmr_q <= tmr_q + 25'h0000001;
          end else if (sdo_q) begin
            state_q <= SH_IDLE;
          end
        end
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  // Result shift on each falling edge the host drives in SH_READ, not during the calibration request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shreg_q <= '0;
    end else if (state_q == SH_READ && fall) begin
      shreg_q <= {shreg_q[RESULT_W-2:0], sdo_q};
    end
  end

  // Unipolar use clears the don't-care sign bit
  assign word = unipolar_i ? {1'b0, shreg_q[RESULT_W-2:0]} : shreg_q;
  assign push = (state_q == SH_READ) && (edges_q == edge_goal) && !sclk_q;

  // Result buffer; a full buffer holds off new conversions
  sarrd_fifo2 #(
    .W (RESULT_W)
  ) u_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (word),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );

  assign idle_o     = (state_q == SH_IDLE);
  assign cal_busy_o = (state_q == SH_CAL) || (state_q == SH_CALWAIT);

endmodule : sarrd_host

// file: tb/sarrd_asserts.sv
/*
 * Link checker: watches the wires between host end and converter end.
 * Assumes one system clock domain and a pulled-up data line.
 */
`timescale 1ns/1ps
module sarrd_asserts
  import sarrd_pkg::*;
#(
  parameter int unsigned CAL_LEN = 200
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic srst_i,
  // Link wires
  input  wire logic conversion_start_select,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  input  wire logic sdo
);
  localparam int CONV_HI = int'(CONV_WAIT) + 1;
  localparam int CAL_LO  = CAL_LEN - 1;
  localparam int CAL_HI  = CAL_LEN + 1;
  logic [7:0]  hi_cnt_q;
  logic [10:0] fall_cnt_q;
  logic [24:0] cal_cnt_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // Cycles with select high
  always_ff @(posedge mclk_i) begin
    if (srst_i || !conversion_start_select) hi_cnt_q <= 8'h00;
    else hi_cnt_q <= hi_cnt_q + 8'h01;
  end

  // Serial clock falls within one select-low frame
  always_ff @(posedge mclk_i) begin
    if (srst_i || conversion_start_select) fall_cnt_q <= 11'h000;
    else if ($fell(sclk)) fall_cnt_q <= fall_cnt_q + 11'h001;
  end

  // Cycles with the data line forced low
  always_ff @(posedge mclk_i) begin
    if (srst_i || !(sdo_oe && !sdo_o)) cal_cnt_q <= 25'h0000000;
    else cal_cnt_q <= cal_cnt_q + 25'h0000001;
  end

  // Result shown while the clock waits low
  sequence s_lead;
    (sdo_oe && !sclk) [*3];
  endsequence
  // Calibration drive on the data line
  sequence s_cal_drive;
    sdo_oe && !sdo_o;
  endsequence

  a_select_rel: assert property (conversion_start_select |-> !sdo_oe && !sclk)
    else $error("data or clock active with select high");
  a_sdo_steady: assert property (sdo_oe && $past(sdo_oe) && sclk && $past(sclk) |-> $stable(sdo_o))
    else $error("data changed while clock high");
  a_conv_wait: assert property ($fell(conversion_start_select) |-> hi_cnt_q == CONV_HI)
    else $error("select low too early or late");
  a_result_shown: assert property ($fell(conversion_start_select) |-> s_lead)
    else $error("result not shown after select fall");
  a_sdo_release: assert property ($rose(fall_cnt_q == 11'h010) |-> ##[0:4] !sdo_oe)
    else $error("data not released after last bit");
  a_cal_drive: assert property ($rose(fall_cnt_q == 11'h400) |-> ##[1:12] s_cal_drive)
    else $error("no calibration drive after request");
  // Frame count keeps rising past the request, so test for at least the request count
  a_cal_length: assert property ($fell(sdo_oe) && fall_cnt_q >= 11'h400 |-> cal_cnt_q inside {[CAL_LO:CAL_HI]})
    else $error("calibration length wrong");
  a_sdi_high: assert property (sdi)
    else $error("serial input not high");
  a_cal_hold: assert property (s_cal_drive and fall_cnt_q >= 11'h400 |-> !conversion_start_select && !sdo)
    else $error("select raised during calibration");
  a_sclk_half: assert property ($rose(sclk) |-> ##1 sclk [*3] ##1 !sclk)
    else $error("serial clock high phase wrong");

endmodule : sarrd_asserts

// file: tb/testbench.sv
/*
 * Bench: host end and converter end joined on one link, plus a second
 * converter end driven by bench tasks at a link rate unrelated to the system clock.
 * Assumes the package constants and a 40 MHz system clock.
 */
`timescale 1ns/1ps
module testbench
  import sarrd_pkg::*;
;
  localparam int unsigned CAL_SIM = 200;
  logic                mclk_i;
  logic                srst_i;
  logic [RESULT_W-1:0] sample_q;
  logic [RESULT_W-1:0] sample2_q;
  logic [RESULT_W-1:0] rdata;
  logic [RESULT_W-1:0] got;
  logic [RESULT_W-1:0] code;
  logic                conv_req, cal_req, uni, rdy, idle, h_cal, d_cal, d2_busy, valid;
  int                  num_errors, n_checks, k;
  int                  cyc = 0;

  sarrd_if link_if ();
  sarrd_if link2_if ();
  sarrd_device #(.CAL_LEN(CAL_SIM)) sarrd_device_i (.mclk_i(mclk_i), .srst_i(srst_i), .sample_i(sample_q),
    .conv_busy_o(), .cal_busy_o(d_cal), .link(link_if.dev));
  sarrd_host sarrd_host_i (.mclk_i(mclk_i), .srst_i(srst_i), .conv_req_i(conv_req), .cal_req_i(cal_req),
    .unipolar_i(uni), .idle_o(idle), .cal_busy_o(h_cal), .res_valid_o(valid), .res_ready_i(rdy),
    .res_data_o(rdata), .link(link_if.host));
  sarrd_device #(.CAL_LEN(CAL_SIM)) sarrd_device_i2 (.mclk_i(mclk_i), .srst_i(srst_i), .sample_i(sample2_q),
    .conv_busy_o(d2_busy), .cal_busy_o(), .link(link2_if.dev));
  sarrd_asserts #(.CAL_LEN(CAL_SIM)) sarrd_asserts_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .conversion_start_select(link_if.conversion_start_select), .sclk(link_if.sclk), .sdi(link_if.sdi),
    .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe), .sdo(link_if.sdo));

  // System clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk16(input string what, input logic [RESULT_W-1:0] exp, input logic [RESULT_W-1:0] seen);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic seen);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk1

  task automatic conv(input logic [RESULT_W-1:0] c);
    @(posedge mclk_i);
    sample_q <= c;
    conv_req <= 1'b1;
    do @(negedge mclk_i); while (idle !== 1'b0);
    @(posedge mclk_i);
    conv_req <= 1'b0;
    do @(negedge mclk_i); while (idle !== 1'b1);
  endtask : conv

  task automatic pop(input logic [RESULT_W-1:0] exp);
    do @(negedge mclk_i); while (valid !== 1'b1);
    chk16("result", exp, rdata);
    @(posedge mclk_i);
    rdy <= 1'b1;
    @(posedge mclk_i);
    rdy <= 1'b0;
  endtask : pop

  // Bench-driven read of the second converter end
  task automatic rd2(input logic [RESULT_W-1:0] c, input int nbits);
    realtime t0;
    @(posedge mclk_i);
    sample2_q <= c;
    got = '0;
    t0 = $realtime;
    #41 link2_if.conversion_start_select = 1'b1;
    #100 link2_if.conversion_start_select = 1'b0;
    #100 link2_if.conversion_start_select = 1'b1;
    wait (d2_busy === 1'b1);
    wait (d2_busy === 1'b0);
    chk1("conversion end", 1'b1, ($realtime - t0) < 900.0);
    #41 link2_if.conversion_start_select = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      link2_if.sclk = 1'b1;
      #80 got[15-i] = link2_if.sdo;
      link2_if.sclk = 1'b0;
      #80;
    end
    if (nbits < 16) link2_if.conversion_start_select = 1'b1;
    #80 chk1("data enable", 1'b0, link2_if.sdo_oe);
    chk16("serial word", c & ~(16'hFFFF >> nbits), got);
    link2_if.conversion_start_select = 1'b0;
  endtask : rd2

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    n_checks = 0;
    srst_i = 1'b1;
    {sample_q, sample2_q, conv_req, cal_req, uni, rdy} = '0;
    link2_if.conversion_start_select = 1'b0;
    link2_if.sclk = 1'b0;
    link2_if.sdi = 1'b1;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    // Fill the buffer while the reader stalls, then drain it
    conv(16'h8000);
    conv(16'h7FFF);
    @(posedge mclk_i);
    conv_req <= 1'b1;
    repeat (100) @(negedge mclk_i);
    chk1("idle while full", 1'b1, idle);
    chk1("select while full", 1'b0, link_if.conversion_start_select);
    @(posedge mclk_i);
    conv_req <= 1'b0;
    pop(16'h8000);
    pop(16'h7FFF);
    @(negedge mclk_i);
    chk1("empty", 1'b0, valid);
    // Sign and unipolar handling
    for (k = 0; k < 4; k++) begin
      code = k[0] ? 16'hFFFF : 16'h0001;
      uni <= k[1];
      conv(code);
      pop(code & {~k[1], 15'h7FFF});
    end
    // Calibration request and its length
    @(posedge mclk_i);
    cal_req <= 1'b1;
    do @(negedge mclk_i); while (h_cal !== 1'b1);
    @(posedge mclk_i);
    cal_req <= 1'b0;
    do @(negedge mclk_i); while (d_cal !== 1'b1);
    chk1("data in calibration", 1'b0, link_if.sdo);
    k = 0;
    do begin
      @(negedge mclk_i);
      k++;
    end while (d_cal === 1'b1);
    chk16("calibration length", 16'(CAL_SIM), 16'(k));
    do @(negedge mclk_i); while (idle !== 1'b1);
    chk1("data released", 1'b1, link_if.sdo);
    conv(16'h1234);
    pop(16'h1234);
    // Second converter end: full read and an early release
    rd2(16'hA5C3, 16);
    rd2(16'h5A3C, 9);
    close_out();
  end

endmodule : testbench
